// ==== design/sdc_pkg.sv ====
// Purpose: Shared constants, types and helpers of the divider config port
// Assumes: pclk is the crystal time base, all pins synchronous to pclk
// Notes: Shift register layout matches the config struct bit for bit
// Function
// (R1) Output is crystal over sixteen, times loop value, over output ratio.
// (R2) Host picks loop value 200 to 400 for a 16 MHz reference.
// (R3) Output select 00,01,10,11 divides by 1,2,4,8.
// (R4) Parallel strobe rising edge captures loop and output divide inputs.
// (R5) Parallel strobe low keeps parallel latches transparent to the inputs.
// (R6) Serial input shifts into a 14-bit shift register.
// (R7) Shift register advances on each serial clock rising edge.
// (R8) Host holds parallel strobe high while loading serially.
// (R9) Serial order: test bits, output divide bits, then loop bits.
// (R10) Each serial field is sent most significant bit first.
// (R11) Serial strobe falling edge moves shifted divide values to counters.
// (R12) Serial strobe high keeps latches transparent to the shift register.
// (R13) Test select comes only from the serial stream.
// (R14) Parallel strobe low forces test select to 000.
// (R15) Observe mux order: shift out, high, ref, loop out, fout, low, tap, fout/4.
// (R16) Test select 110 bypasses the loop, serial clock drives both dividers.
// (R17) In bypass the output divider divides by at least two.
// (R18) Loop counter output on observe pin has no 50% duty.
// (R19) Parallel strobe low resets observe latch; pin shows top shift bit.
// (R20) Host sets values at power-up in parallel, later serially.
// (R21) Counters adopt a new modulus only at their terminal count.
package sdc_pkg;
   localparam int M_W = 9;
   localparam int N_W = 2;
   localparam int T_W = 3;
   localparam int SR_W = 14;
   localparam int REF_DIV = 16;
   localparam int REF_W = 4;
   localparam int M_MIN = 200;
   localparam int M_MAX = 400;
   localparam int AW = 8;

   localparam logic [AW-1:0] CTRL_ADDR = 8'h00;
   localparam logic [AW-1:0] STAT_ADDR = 8'h04;
   localparam logic [AW-1:0] SHIFT_ADDR = 8'h08;
   localparam int CTRL_OE_BIT = 0;
   localparam logic CTRL_OE_RST = 1'b1;
   localparam int STAT_M_LSB = 0;
   localparam int STAT_N_LSB = 9;
   localparam int STAT_T_LSB = 11;
   localparam int STAT_PLOAD_BIT = 14;
   localparam int STAT_BYP_BIT = 15;
   localparam int STAT_FOUT_BIT = 16;

   localparam logic [T_W-1:0] TS_SHIFT = 3'h0;
   localparam logic [T_W-1:0] TS_HIGH = 3'h1;
   localparam logic [T_W-1:0] TS_REF = 3'h2;
   localparam logic [T_W-1:0] TS_LOOP = 3'h3;
   localparam logic [T_W-1:0] TS_FOUT = 3'h4;
   localparam logic [T_W-1:0] TS_LOW = 3'h5;
   localparam logic [T_W-1:0] TS_BYPASS = 3'h6;
   localparam logic [T_W-1:0] TS_FOUT4 = 3'h7;
   localparam logic [N_W-1:0] N_MIN_BYP = 2'h1;

   typedef struct packed {
      logic [T_W-1:0] t;
      logic [N_W-1:0] n;
      logic [M_W-1:0] m;
   } sdc_cfg_s;

   // Output ratio in ticks per half period
   function automatic logic [3:0] sdc_ratio(input logic [N_W-1:0] code);
      sdc_ratio = 4'h1 << code;
   endfunction : sdc_ratio

   function automatic logic sdc_rise(input logic now, input logic last);
      sdc_rise = now & ~last;
   endfunction : sdc_rise
endpackage : sdc_pkg

// ==== design/sdc_loop_div.sv ====
// Purpose: Loop divider counting feedback ticks by the loop modulus
// Assumes: tick is a one-cycle enable pulse
// Notes: Modulus is sampled only at terminal count
`timescale 1ns/100ps
`default_nettype none
module sdc_loop_div
   import sdc_pkg::*;
#(
   parameter int W = M_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic [W-1:0] modulus,
   output logic term,
   output logic cnt_out,
   output logic tap
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic next_term;
   logic next_out;

   initial begin
      if (W < 2) $error("sdc_loop_div: W must be at least 2");
   end

   always_comb begin
      next_cnt = cnt;
      next_term = 1'b0;
      next_out = cnt_out;
      if (tick) begin
         if (cnt == '0) begin
            // New modulus taken here only
            next_cnt = (modulus == '0) ? '0 : modulus - 1'b1; // R21
            next_term = 1'b1;
            next_out = 1'b1;
         end else begin
            next_cnt = cnt - 1'b1;
            next_out = 1'b0; // R18
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         term <= 1'b0;
         cnt_out <= 1'b0;
      end else begin
         cnt <= next_cnt;
         term <= next_term;
         cnt_out <= next_out;
      end
   end

   assign tap = cnt[W-1];
endmodule : sdc_loop_div
`default_nettype wire

// ==== design/sdc_out_div.sv ====
// Purpose: Output divider by 1, 2, 4 or 8 with even duty
// Assumes: tick marks one half period of the source
// Notes: Ratio is held until the current half period ends
`timescale 1ns/100ps
`default_nettype none
module sdc_out_div
   import sdc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic [N_W-1:0] code,
   output logic fout
);
   logic [3:0] cnt;
   logic [3:0] ratio;
   logic [3:0] next_cnt;
   logic [3:0] next_ratio;
   logic next_fout;

   always_comb begin
      next_cnt = cnt;
      next_ratio = ratio;
      next_fout = fout;
      if (tick) begin
         if (cnt >= ratio - 4'h1) begin
            next_cnt = 4'h0;
            next_fout = ~fout;
            next_ratio = sdc_ratio(code); // R3 R21
         end else begin
            next_cnt = cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 4'h0;
         ratio <= 4'h1;
         fout <= 1'b0;
      end else begin
         cnt <= next_cnt;
         ratio <= next_ratio;
         fout <= next_fout;
      end
   end
endmodule : sdc_out_div
`default_nettype wire

// ==== design/sdc_config_port.sv ====
// Purpose: Divider configuration port of a crystal based synthesizer
// Assumes: pclk is the crystal; vco_tick marks each oscillator half period
// Notes: Parallel port wins over serial; APB adds enable and status view
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module sdc_config_port
   import sdc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic par_load,
   input wire logic [M_W-1:0] m_in,
   input wire logic [N_W-1:0] n_in,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_load,
   input wire logic vco_tick,
   output logic fout,
   output logic observe,
   output logic pump_up,
   output logic pump_dn
);
   // Serial side
   logic [SR_W-1:0] shift;
   logic [SR_W-1:0] next_shift;
   logic ser_clk_q;
   logic sclk_rise;

   // Configuration latches
   sdc_cfg_s cfg;
   sdc_cfg_s next_cfg;
   sdc_cfg_s active;
   logic parallel_load_low;
   logic bypass;

   // Reference and dividers
   logic [REF_W-1:0] ref_cnt;
   logic [REF_W-1:0] next_ref_cnt;
   logic reference_compare_clock;
   logic ref_pulse;
   logic loop_tick;
   logic loop_term;
   logic loop_out;
   logic loop_count_tap;
   logic [N_W-1:0] out_code;
   logic fout_raw;
   logic fout_q;
   logic [1:0] div4_cnt;
   logic [1:0] next_div4_cnt;
   logic next_pump_up;
   logic next_pump_dn;

   // Observe and output gating
   logic next_observe;
   logic oe_ctrl;
   logic oe_eff;
   logic next_oe_eff;
   logic next_fout;

   // Register access
   logic wr_en;
   logic next_oe_ctrl;
   logic [31:0] rd_val;
   logic [31:0] next_prdata;
   logic addr_ok;

   initial begin
      if (REF_DIV != (1 << REF_W)) $error("sdc: REF_DIV must be 2**REF_W");
      if (SR_W != T_W + N_W + M_W) $error("sdc: shift width mismatch");
      if (N_MIN_BYP == '0) $error("sdc: bypass ratio too low");
      if (STAT_T_LSB + T_W > STAT_PLOAD_BIT) $error("sdc: status overlap");
   end

   assign parallel_load_low = ~par_load;
   assign sclk_rise = sdc_rise(ser_clk, ser_clk_q);

   // Shift register, top field lands in the top bits
   always_comb begin
      next_shift = shift;
      if (sclk_rise) begin // R7
         next_shift = {shift[SR_W-2:0], ser_data}; // R6 R9 R10
      end
   end

   // Latch view: parallel transparent while low, serial while strobe high
   always_comb begin
      if (parallel_load_low) begin
         active.t = '0; // R13 R14
         active.n = n_in; // R5
         active.m = m_in; // R5
      end else if (ser_load) begin
         active = sdc_cfg_s'(shift); // R12
      end else begin
         active = cfg; // R4 R11
      end
      next_cfg = active;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift <= '0;
         ser_clk_q <= 1'b0;
      end else begin
         shift <= next_shift;
         ser_clk_q <= ser_clk;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= '0;
      end else begin
         cfg <= next_cfg;
      end
   end

   // Crystal divided by sixteen gives the compare clock
   assign bypass = (active.t == TS_BYPASS); // R16
   always_comb begin
      next_ref_cnt = ref_cnt + 4'h1; // R1
   end
   assign reference_compare_clock = ref_cnt[REF_W-1];
   assign ref_pulse = (ref_cnt == '1);

   // Bypass feeds serial clock edges straight to both dividers
   assign loop_tick = bypass ? sclk_rise : vco_tick; // R16
   assign out_code = (bypass && active.n < N_MIN_BYP) ? N_MIN_BYP
      : active.n; // R17

   sdc_loop_div #(
      .W(M_W)
   ) u_loop (
      .clk(pclk),
      .rst_n(presetn),
      .tick(loop_tick),
      .modulus(active.m),
      .term(loop_term),
      .cnt_out(loop_out),
      .tap(loop_count_tap)
   );

   sdc_out_div u_out (
      .clk(pclk),
      .rst_n(presetn),
      .tick(loop_tick),
      .code(out_code),
      .fout(fout_raw)
   );

   // Phase detector drives loop toward ref times loop modulus
   always_comb begin
      next_pump_up = pump_up;
      next_pump_dn = pump_dn;
      if (bypass || (ref_pulse && loop_term)) begin
         next_pump_up = 1'b0;
         next_pump_dn = 1'b0;
      end else if (ref_pulse) begin
         next_pump_up = ~pump_dn; // R1
         next_pump_dn = 1'b0;
      end else if (loop_term) begin
         next_pump_dn = ~pump_up; // R1
         next_pump_up = 1'b0;
      end
   end

   // Divide by four of the output for the observe mux
   always_comb begin
      next_div4_cnt = div4_cnt;
      if (sdc_rise(fout_raw, fout_q)) begin
         next_div4_cnt = div4_cnt + 2'h1;
      end
   end

   // Observe mux; latch held in reset by parallel strobe low
   always_comb begin
      if (parallel_load_low) begin
         next_observe = shift[SR_W-1]; // R19
      end else begin
         case (active.t) // R15
            TS_SHIFT: next_observe = shift[SR_W-1];
            TS_HIGH: next_observe = 1'b1;
            TS_REF: next_observe = reference_compare_clock;
            TS_LOOP: next_observe = loop_out; // R18
            TS_FOUT: next_observe = fout_raw;
            TS_LOW: next_observe = 1'b0;
            TS_BYPASS: next_observe = loop_count_tap; // R16
            TS_FOUT4: next_observe = div4_cnt[1];
            default: next_observe = 1'b0;
         endcase
      end
   end

   // Output enable changes only while output is low, no runt pulses
   always_comb begin
      next_oe_eff = oe_eff;
      if (!fout_raw) begin
         next_oe_eff = oe_ctrl;
      end
      next_fout = fout_raw & oe_eff;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_cnt <= '0;
      end else begin
         ref_cnt <= next_ref_cnt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pump_up <= 1'b0;
         pump_dn <= 1'b0;
      end else begin
         pump_up <= next_pump_up;
         pump_dn <= next_pump_dn;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fout_q <= 1'b0;
         div4_cnt <= 2'h0;
      end else begin
         fout_q <= fout_raw;
         div4_cnt <= next_div4_cnt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         observe <= 1'b0;
      end else begin
         observe <= next_observe;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_eff <= CTRL_OE_RST;
         fout <= 1'b0;
      end else begin
         oe_eff <= next_oe_eff;
         fout <= next_fout;
      end
   end

   // APB slave, zero wait states, read data staged in setup
   assign addr_ok = (paddr == CTRL_ADDR) || (paddr == STAT_ADDR)
      || (paddr == SHIFT_ADDR);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign wr_en = psel & penable & pwrite & (paddr == CTRL_ADDR);

   always_comb begin
      rd_val = 32'h0;
      case (paddr)
         CTRL_ADDR: rd_val[CTRL_OE_BIT] = oe_ctrl;
         STAT_ADDR: begin
            rd_val[STAT_M_LSB +: M_W] = active.m;
            rd_val[STAT_N_LSB +: N_W] = active.n;
            rd_val[STAT_T_LSB +: T_W] = active.t;
            rd_val[STAT_PLOAD_BIT] = par_load;
            rd_val[STAT_BYP_BIT] = bypass;
            rd_val[STAT_FOUT_BIT] = fout;
         end
         SHIFT_ADDR: rd_val[SR_W-1:0] = shift;
         default: rd_val = 32'h0;
      endcase
   end

   always_comb begin
      next_prdata = prdata;
      if (psel && !penable) begin
         next_prdata = rd_val;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else begin
         prdata <= next_prdata;
      end
   end

   always_comb begin
      next_oe_ctrl = wr_en ? pwdata[CTRL_OE_BIT] : oe_ctrl;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_ctrl <= CTRL_OE_RST;
      end else begin
         oe_ctrl <= next_oe_ctrl;
      end
   end
endmodule : sdc_config_port
`default_nettype wire

// ==== test/sdc_host_model.sv ====
// Purpose: Host pin driver of the divider config port
// Assumes: Pins change right after pclk rising edges
// Notes: Serial clock idles low, serial data rests at pulldown level
`timescale 1ns/100ps
`default_nettype none
module sdc_host_model
   import sdc_pkg::*;
(
   input wire logic pclk,
   output logic par_load,
   output logic [M_W-1:0] m_in,
   output logic [N_W-1:0] n_in,
   output logic ser_clk,
   output logic ser_data,
   output logic ser_load,
   output logic vco_tick
);
   int ph = 0;
   initial begin
      par_load = 1'b0;
      m_in = 9'h106;
      n_in = 2'h1;
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_load = 1'b0;
      vco_tick = 1'b0;
   end
   // One oscillator half period every third cycle
   always @(posedge pclk) begin
      ph <= (ph + 1) % 3;
      vco_tick <= (ph == 0);
   end
   task automatic pins(input logic [M_W-1:0] m, input logic [N_W-1:0] n);
      @(posedge pclk);
      m_in <= m;
      n_in <= n;
      @(posedge pclk);
   endtask : pins
   task automatic pload(input logic v);
      @(posedge pclk);
      par_load <= v;
   endtask : pload
   task automatic ser_cfg(input sdc_cfg_s c);
      for (int i = SR_W - 1; i >= 0; i--) begin
         @(posedge pclk);
         ser_data <= c[i];
         ser_clk <= 1'b0;
         @(posedge pclk);
         ser_clk <= 1'b1;
      end
      @(posedge pclk);
      ser_clk <= 1'b0;
      ser_data <= 1'b0;
      @(posedge pclk);
      ser_load <= 1'b1;
      repeat (2) @(posedge pclk);
      ser_load <= 1'b0;
      @(posedge pclk);
   endtask : ser_cfg
endmodule : sdc_host_model
`default_nettype wire

// ==== test/sdc_port_assertions.sv ====
// Purpose: Port assertions of the divider config port
// Assumes: One pclk domain, reset presetn
// Notes: Shadows shift register and test select
`timescale 1ns/100ps
`default_nettype none
module sdc_port_checker
   import sdc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic par_load,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_load,
   input wire logic observe
);
   logic sclk_q, next_sclk_q, acc, unmap;
   logic [SR_W-1:0] sr, next_sr;
   logic [T_W-1:0] t_q, next_t_q;
   always_comb begin
      next_sclk_q = ser_clk;
      next_sr = sr;
      if (ser_clk && !sclk_q) begin
         next_sr = {sr[SR_W-2:0], ser_data};
      end
      next_t_q = ser_load ? sr[SR_W-1:SR_W-T_W] : t_q;
      if (!par_load) begin
         next_t_q = TS_SHIFT;
      end
      acc = psel && penable;
      unmap = paddr != CTRL_ADDR && paddr != STAT_ADDR;
      unmap = unmap && paddr != SHIFT_ADDR;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_q <= 1'b0;
         sr <= '0;
         t_q <= '0;
      end else begin
         sclk_q <= next_sclk_q;
         sr <= next_sr;
         t_q <= next_t_q;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_quiet;
      $stable(par_load) && $stable(next_t_q);
   endsequence
   sequence s_stat_rd;
      (psel && !penable && !pwrite && paddr == STAT_ADDR) ##0 s_quiet
      ##1 acc ##0 s_quiet;
   endsequence
   AST_READY: assert property (acc |-> pready)
      else $error("pready low in access");
   AST_ERR: assert property (acc && unmap |-> pslverr)
      else $error("no error on unmapped access");
   AST_NOERR: assert property (acc && !unmap |-> !pslverr)
      else $error("error on mapped access");
   AST_RD0: assert property (acc && unmap && !pwrite |-> prdata == '0)
      else $error("unmapped read not zero");
   AST_PLBIT: assert property (
      s_stat_rd |-> prdata[STAT_PLOAD_BIT] == par_load)
      else $error("status strobe bit wrong");
   AST_TSTAT: assert property (
      s_stat_rd |-> prdata[STAT_T_LSB+:T_W] == next_t_q)
      else $error("status test select wrong");
   AST_OBS_SHIFT: assert property (
      !par_load && !$past(par_load) |-> observe == $past(sr[SR_W-1]))
      else $error("observe not top shift bit");
   AST_HIGH: assert property ((next_t_q == TS_HIGH) [*3] |-> observe)
      else $error("observe not high");
   AST_LOW: assert property ((next_t_q == TS_LOW) [*3] |-> !observe)
      else $error("observe not low");
endmodule : sdc_port_checker
bind sdc_config_port sdc_port_checker chk_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .par_load(par_load), .ser_clk(ser_clk), .ser_data(ser_data),
   .ser_load(ser_load), .observe(observe));
`default_nettype wire

// ==== test/sdc_config_port_bench.sv ====
// Purpose: Self-checking bench of the divider config port
// Assumes: Host model drives the pins, bench drives APB
// Notes: Port checker is bound into the design
`timescale 1ns/100ps
`default_nettype none
module sdc_config_port_bench
   import sdc_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic fout, observe, par_load, ser_clk, ser_data, ser_load, vco_tick;
   logic [AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [M_W-1:0] m_in;
   logic [N_W-1:0] n_in;
   int err_count = 0;
   int checks = 0;
   int nt;
   sdc_config_port uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .par_load(par_load), .m_in(m_in), .n_in(n_in), .ser_clk(ser_clk),
      .ser_data(ser_data), .ser_load(ser_load), .vco_tick(vco_tick),
      .fout(fout), .observe(observe), .pump_up(), .pump_dn());
   sdc_host_model host (.pclk(pclk), .par_load(par_load), .m_in(m_in),
      .n_in(n_in), .ser_clk(ser_clk), .ser_data(ser_data),
      .ser_load(ser_load), .vco_tick(vco_tick));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [AW-1:0] a);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {31'h0, 1'b0};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic stat(input logic [M_W-1:0] m, input logic [N_W-1:0] n,
      input logic [T_W-1:0] t, input logic pl);
      apb(1'b0, STAT_ADDR);
      chk(rd & 32'h0000_7FFF, {17'h0, pl, t, n, m});
   endtask : stat
   // Counts edges of fout or observe, away from the launching edge
   task automatic fcount(input int cyc, input logic obs);
      logic last;
      last = obs ? observe : fout;
      nt = 0;
      repeat (cyc) begin
         @(negedge pclk);
         if ((obs ? observe : fout) !== last) begin
            nt++;
         end
         last = obs ? observe : fout;
      end
   endtask : fcount
   task automatic end_of_test;
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #(40 * 20000);
      err_count++;
      end_of_test();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CTRL_ADDR);
      chk(rd, 32'h0000_0001);
      host.pins(9'h106, 2'h1);
      stat(9'h106, 2'h1, TS_SHIFT, 1'b0);
      host.pins(9'h12C, 2'h2);
      stat(9'h12C, 2'h2, TS_SHIFT, 1'b0);
      host.pload(1'b1);
      host.pins(9'h15E, 2'h3);
      stat(9'h12C, 2'h2, TS_SHIFT, 1'b1);
      host.ser_cfg({TS_HIGH, 2'h3, 9'h0C8});
      apb(1'b0, SHIFT_ADDR);
      chk(rd, 32'h0000_0EC8);
      stat(9'h0C8, 2'h3, TS_HIGH, 1'b1);
      host.ser_cfg({TS_LOW, 2'h0, 9'h104});
      stat(9'h104, 2'h0, TS_LOW, 1'b1);
      host.ser_cfg({TS_BYPASS, 2'h0, 9'h004});
      apb(1'b0, STAT_ADDR);
      chk({31'h0, rd[STAT_BYP_BIT]}, 32'h1);
      fork
         host.ser_cfg({TS_BYPASS, 2'h0, 9'h004});
         fcount(30, 1'b0);
      join
      chk({31'h0, nt >= 1 && nt <= 7}, 32'h1);
      host.ser_cfg({TS_REF, 2'h1, 9'h106});
      fcount(160, 1'b1);
      chk({31'h0, nt >= 19 && nt <= 21}, 32'h1);
      host.ser_cfg({TS_FOUT, 2'h1, 9'h106});
      fcount(120, 1'b1);
      chk({31'h0, nt >= 19 && nt <= 21}, 32'h1);
      host.ser_cfg({TS_FOUT4, 2'h1, 9'h106});
      fcount(240, 1'b1);
      chk({31'h0, nt >= 9 && nt <= 11}, 32'h1);
      host.ser_cfg({TS_LOOP, 2'h1, 9'h0C8});
      fcount(1300, 1'b1);
      chk({31'h0, nt >= 2 && nt <= 6}, 32'h1);
      host.pload(1'b0);
      stat(9'h15E, 2'h3, TS_SHIFT, 1'b0);
      fcount(240, 1'b0);
      chk({31'h0, nt >= 9 && nt <= 11}, 32'h1);
      apb(1'b1, CTRL_ADDR);
      apb(1'b0, CTRL_ADDR);
      chk(rd, 32'h0);
      // Enable only drops once the output is low
      repeat (30) @(posedge pclk);
      fcount(80, 1'b0);
      chk(32'(nt), 32'h0);
      apb(1'b0, 8'h0C);
      chk(rd, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, 8'h0C);
      chk({31'h0, er}, 32'h1);
      end_of_test();
   end
endmodule : sdc_config_port_bench
`default_nettype wire
